// ==== src/stop_reaction_pkg.sv ====
// Purpose: Constants for the drive stop reaction selector
// Assumes: Object dictionary access through a simple index port
// Notes:   Option codes are signed 16-bit values
package stop_reaction_pkg;

    // ------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_QUICK_STOP = 16'h605a;
    localparam logic [15:0] IDX_SHUTDOWN   = 16'h605b;
    localparam logic [15:0] IDX_DISABLE    = 16'h605c;
    localparam logic [15:0] IDX_HALT       = 16'h605d;
    localparam logic [15:0] IDX_FAULT      = 16'h605e;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_QUICK_STOP = 16'h0002;
    localparam logic [15:0] RST_SHUTDOWN   = 16'h0001;
    localparam logic [15:0] RST_DISABLE    = 16'h0001;
    localparam logic [15:0] RST_HALT       = 16'h0001;
    localparam logic [15:0] RST_FAULT      = 16'h0002;

    // ------------------------------------------------------------
    // Option codes
    // ------------------------------------------------------------
    localparam logic signed [15:0] OPT_0 = 16'sh0000;
    localparam logic signed [15:0] OPT_1 = 16'sh0001;
    localparam logic signed [15:0] OPT_2 = 16'sh0002;
    localparam logic signed [15:0] OPT_5 = 16'sh0005;
    localparam logic signed [15:0] OPT_6 = 16'sh0006;

    // Control word halt bit
    localparam int HALT_BIT = 8;

    // ------------------------------------------------------------
    // Stop actions and follow-up states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ACT_NONE      = 3'h0,
        ACT_COAST     = 3'h1,
        ACT_SLOW_RAMP = 3'h2,
        ACT_QS_RAMP   = 3'h3,
        ACT_IMMEDIATE = 3'h4
    } action_t;

    typedef enum logic [1:0] {
        NEXT_HOLD     = 2'h0,
        NEXT_SOD      = 2'h1,
        NEXT_QS_ACT   = 2'h2,
        NEXT_OP_EN    = 2'h3
    } follow_t;

    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0001,
        ST_BRAKING = 4'b0010,
        ST_QS_HOLD = 4'b0100,
        ST_DONE    = 4'b1000
    } state_t;

endpackage : stop_reaction_pkg

// ==== src/drive_stop_reaction_select.sv ====
// Purpose: Selects stop action and following state for drive events
// Assumes: Ramp generators report braking completion via brake_done
// Notes:   Reserved codes fall back to coasting, the safest reaction; reserved quick stop codes stop immediately
`timescale 1ns/1ns
`default_nettype none

module drive_stop_reaction_select #(
    parameter int DATA_W = 16
) (
    input  wire logic                             clk,
    input  wire logic                             rst,
    input  wire logic                             clk_en,
    input  wire logic                             obj_wr,
    input  wire logic                             obj_rd,
    input  wire logic [15:0]                      obj_index,
    input  wire logic [DATA_W-1:0]                obj_wdata,
    output var  logic [DATA_W-1:0]                obj_rdata,
    output var  logic                             obj_ack,
    output var  logic                             obj_err,
    input  wire logic [15:0]                      control_word,
    input  wire logic                             quick_stop_req,
    input  wire logic                             shutdown_req,
    input  wire logic                             disable_req,
    input  wire logic                             fault_req,
    input  wire logic                             resume_req,
    input  wire logic                             brake_done,
    output var  stop_reaction_pkg::action_t       stop_action,
    output var  stop_reaction_pkg::follow_t       next_power_state,
    output var  logic                             drive_energized,
    output var  logic                             halt_active
);

    // ------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------
    // Option words and decode are fixed at one 16-bit word
    if (DATA_W != 16)
    begin : g_width_check
        $error("DATA_W must be 16");
    end

    if (stop_reaction_pkg::HALT_BIT > 15)
    begin : g_halt_bit_check
        $error("HALT_BIT must lie inside the control word");
    end

    // ------------------------------------------------------------
    // Option registers
    // ------------------------------------------------------------
    logic signed [15:0] quick_stop_reaction;
    logic signed [15:0] shutdown_reaction;
    logic signed [15:0] disable_reaction;
    logic signed [15:0] halt_reaction;
    logic signed [15:0] fault_reaction;

    wire hit_qs  = obj_index == stop_reaction_pkg::IDX_QUICK_STOP;
    wire hit_sd  = obj_index == stop_reaction_pkg::IDX_SHUTDOWN;
    wire hit_dis = obj_index == stop_reaction_pkg::IDX_DISABLE;
    wire hit_hlt = obj_index == stop_reaction_pkg::IDX_HALT;
    wire hit_flt = obj_index == stop_reaction_pkg::IDX_FAULT;
    wire hit_any = hit_qs | hit_sd | hit_dis | hit_hlt | hit_flt;
    wire obj_req = obj_wr | obj_rd;

    wire [15:0] next_rdata = hit_qs  ? quick_stop_reaction :
                             hit_sd  ? shutdown_reaction :
                             hit_dis ? disable_reaction :
                             hit_hlt ? halt_reaction :
                             hit_flt ? fault_reaction : 16'h0000;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            quick_stop_reaction <= stop_reaction_pkg::RST_QUICK_STOP;
            shutdown_reaction   <= stop_reaction_pkg::RST_SHUTDOWN;
            disable_reaction    <= stop_reaction_pkg::RST_DISABLE;
            halt_reaction       <= stop_reaction_pkg::RST_HALT;
            fault_reaction      <= stop_reaction_pkg::RST_FAULT;
        end
        else if (clk_en && obj_wr)
        begin
            if (hit_qs)
                quick_stop_reaction <= obj_wdata;
            if (hit_sd)
                shutdown_reaction <= obj_wdata;
            if (hit_dis)
                disable_reaction <= obj_wdata;
            if (hit_hlt)
                halt_reaction <= obj_wdata;
            if (hit_flt)
                fault_reaction <= obj_wdata;
        end
    end

    // Answer stands one cycle; an unmapped index is refused
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            obj_rdata <= 16'h0000;
            obj_ack   <= 1'b0;
            obj_err   <= 1'b0;
        end
        else if (clk_en)
        begin
            obj_ack   <= obj_req & hit_any;
            obj_err   <= obj_req & ~hit_any;
            obj_rdata <= (obj_rd & hit_any) ? next_rdata : 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // Code decoding
    // ------------------------------------------------------------
    // Reserved codes coast: the least energetic reaction is safest
    function automatic stop_reaction_pkg::action_t ramp_code(
        input logic signed [15:0] code
    );
        case (code)
            stop_reaction_pkg::OPT_0: ramp_code = stop_reaction_pkg::ACT_COAST;
            stop_reaction_pkg::OPT_1: ramp_code = stop_reaction_pkg::ACT_SLOW_RAMP;
            stop_reaction_pkg::OPT_2: ramp_code = stop_reaction_pkg::ACT_QS_RAMP;
            default:                  ramp_code = stop_reaction_pkg::ACT_COAST;
        endcase
    endfunction : ramp_code

    // Halt codes 0 and below are reserved
    wire stop_reaction_pkg::action_t halt_act =
        (halt_reaction == stop_reaction_pkg::OPT_0)
            ? stop_reaction_pkg::ACT_COAST
            : ramp_code(halt_reaction);

    wire stop_reaction_pkg::action_t fault_act =
        ramp_code(fault_reaction);

    // Shutdown/disable code 2 reserved, so mask it off
    wire signed [15:0] sd_code  = (shutdown_reaction == stop_reaction_pkg::OPT_2)
                                  ? 16'shffff : shutdown_reaction;
    wire signed [15:0] dis_code = (disable_reaction == stop_reaction_pkg::OPT_2)
                                  ? 16'shffff : disable_reaction;

    logic                       qs_hold_mode;
    stop_reaction_pkg::action_t qs_act;
    always_comb
    begin
        qs_hold_mode = 1'b0;
        case (quick_stop_reaction)
            stop_reaction_pkg::OPT_0: qs_act = stop_reaction_pkg::ACT_IMMEDIATE;
            stop_reaction_pkg::OPT_1: qs_act = stop_reaction_pkg::ACT_SLOW_RAMP;
            stop_reaction_pkg::OPT_2: qs_act = stop_reaction_pkg::ACT_QS_RAMP;
            stop_reaction_pkg::OPT_5:
            begin
                qs_act       = stop_reaction_pkg::ACT_SLOW_RAMP;
                qs_hold_mode = 1'b1;
            end
            stop_reaction_pkg::OPT_6:
            begin
                qs_act       = stop_reaction_pkg::ACT_QS_RAMP;
                qs_hold_mode = 1'b1;
            end
            default:                  qs_act = stop_reaction_pkg::ACT_IMMEDIATE;
        endcase
    end

    // ------------------------------------------------------------
    // Event sequencing
    // ------------------------------------------------------------
    stop_reaction_pkg::state_t  state;
    stop_reaction_pkg::state_t  next_state;
    stop_reaction_pkg::action_t next_action;
    stop_reaction_pkg::follow_t next_follow;
    logic                       held_hold_mode;
    logic                       next_hold_mode;
    logic                       next_energized;
    logic                       halt_prev;

    // Edge detector idles low like the halt bit: no false edge
    wire halt_bit  = control_word[stop_reaction_pkg::HALT_BIT];
    wire halt_rise = halt_bit & ~halt_prev;

    // Taken in IDLE/DONE only; events while busy are refused
    wire event_req = fault_req | quick_stop_req | disable_req
                   | shutdown_req | halt_rise;

    always_comb
    begin
        next_state     = state;
        next_action    = stop_action;
        next_follow    = next_power_state;
        next_hold_mode = held_hold_mode;
        next_energized = drive_energized;
        case (state)
            stop_reaction_pkg::ST_IDLE, stop_reaction_pkg::ST_DONE:
            begin
                // Events start from an energized drive
                if (event_req)
                    next_energized = 1'b1;
                // Priority: fault, quick stop, disable, shutdown, halt
                if (fault_req)
                begin
                    next_action = fault_act;
                    next_follow = stop_reaction_pkg::NEXT_HOLD;
                    next_hold_mode = 1'b0;
                    next_state  = stop_reaction_pkg::ST_BRAKING;
                end
                else if (quick_stop_req)
                begin
                    next_action    = qs_act;
                    next_hold_mode = qs_hold_mode;
                    next_follow    = stop_reaction_pkg::NEXT_HOLD;
                    next_state     = stop_reaction_pkg::ST_BRAKING;
                end
                else if (disable_req || shutdown_req)
                begin
                    next_action = ramp_code(disable_req ? dis_code
                                                        : sd_code);
                    next_follow = stop_reaction_pkg::NEXT_HOLD;
                    next_hold_mode = 1'b0;
                    next_state  = stop_reaction_pkg::ST_BRAKING;
                end
                else if (halt_rise)
                begin
                    next_action = halt_act;
                    next_follow = stop_reaction_pkg::NEXT_HOLD;
                    next_hold_mode = 1'b1;
                    next_state  = stop_reaction_pkg::ST_BRAKING;
                end
            end
            stop_reaction_pkg::ST_BRAKING:
            begin
                if (next_action == stop_reaction_pkg::ACT_COAST)
                    next_energized = 1'b0;
                if (brake_done ||
                    stop_action == stop_reaction_pkg::ACT_IMMEDIATE ||
                    stop_action == stop_reaction_pkg::ACT_COAST)
                begin
                    if (held_hold_mode)
                    begin
                        next_follow = stop_reaction_pkg::NEXT_QS_ACT;
                        next_state  = stop_reaction_pkg::ST_QS_HOLD;
                    end
                    else
                    begin
                        next_follow    = stop_reaction_pkg::NEXT_SOD;
                        next_energized = 1'b0;
                        next_state     = stop_reaction_pkg::ST_DONE;
                    end
                end
            end
            stop_reaction_pkg::ST_QS_HOLD:
            begin
                if (resume_req)
                begin
                    next_follow = stop_reaction_pkg::NEXT_OP_EN;
                    next_action = stop_reaction_pkg::ACT_NONE;
                    next_state  = stop_reaction_pkg::ST_IDLE;
                    next_energized = 1'b1;
                end
            end
            default:
                next_state = stop_reaction_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state            <= stop_reaction_pkg::ST_IDLE;
            stop_action      <= stop_reaction_pkg::ACT_NONE;
            next_power_state <= stop_reaction_pkg::NEXT_HOLD;
            held_hold_mode   <= 1'b0;
            drive_energized  <= 1'b1;
            halt_prev        <= 1'b0;
            halt_active      <= 1'b0;
        end
        else if (clk_en)
        begin
            state            <= next_state;
            stop_action      <= next_action;
            next_power_state <= next_follow;
            held_hold_mode   <= next_hold_mode;
            drive_energized  <= next_energized;
            halt_prev        <= halt_bit;
            halt_active      <= halt_bit;
        end
    end

endmodule : drive_stop_reaction_select

`default_nettype wire

// ==== verification/drive_stop_reaction_select_asserts.sv ====
// Purpose: Port assertions for the stop reaction selector
// Assumes: requests count only on edges with clk_en high
// Notes:   Bound to every instance of the design
`timescale 1ns/1ns
`default_nettype none
module drive_stop_reaction_select_asserts #(
    parameter int DATA_W = 16
) (
    input  wire logic                       clk,
    input  wire logic                       rst,
    input  wire logic                       clk_en,
    input  wire logic                       obj_wr,
    input  wire logic                       obj_rd,
    input  wire logic [15:0]                obj_index,
    input  wire logic [DATA_W-1:0]          obj_wdata,
    input  wire logic [DATA_W-1:0]          obj_rdata,
    input  wire logic                       obj_ack,
    input  wire logic                       obj_err,
    input  wire logic [15:0]                control_word,
    input  wire logic                       resume_req,
    input  wire logic                       brake_done,
    input  wire stop_reaction_pkg::action_t stop_action,
    input  wire stop_reaction_pkg::follow_t next_power_state,
    input  wire logic                       drive_energized,
    input  wire logic                       halt_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    wire logic mapped;
    wire logic access;
    wire logic ramp;
    assign mapped = obj_index inside {[16'h605a:16'h605e]};
    assign access = clk_en && (obj_wr || obj_rd);
    assign ramp   = stop_action inside {stop_reaction_pkg::ACT_SLOW_RAMP,
                                        stop_reaction_pkg::ACT_QS_RAMP};
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_ack_mapped: assert property (access && mapped |=> obj_ack && !obj_err)
        else $error("mapped access not acknowledged");
    a_err_unmapped: assert property (access && !mapped
        |=> obj_err && !obj_ack && obj_rdata == '0)
        else $error("unmapped access not refused");
    a_write_readback: assert property (clk_en && obj_wr && mapped
        ##1 clk_en && !obj_wr ##1 clk_en && obj_rd && !obj_wr
        && obj_index == $past(obj_index, 2)
        |=> obj_rdata == $past(obj_wdata, 3))
        else $error("option read back differs from write");
    a_halt_copy: assert property (clk_en |=> halt_active == $past(control_word[8]))
        else $error("halt flag does not follow control bit");
    a_immediate_sod: assert property (clk_en && $changed(stop_action)
        && stop_action == stop_reaction_pkg::ACT_IMMEDIATE
        |=> next_power_state == stop_reaction_pkg::NEXT_SOD)
        else $error("immediate stop not followed by disable state");
    a_qs_energized: assert property (
        next_power_state == stop_reaction_pkg::NEXT_QS_ACT |-> drive_energized)
        else $error("motor not energized in quick stop hold");
    a_qs_resume: assert property (clk_en && resume_req
        && next_power_state == stop_reaction_pkg::NEXT_QS_ACT
        |=> next_power_state == stop_reaction_pkg::NEXT_OP_EN)
        else $error("resume did not reach operation enabled");
    a_ramp_finish: assert property (clk_en && brake_done && ramp
        && next_power_state == stop_reaction_pkg::NEXT_HOLD
        |=> next_power_state != stop_reaction_pkg::NEXT_HOLD)
        else $error("braking end not followed by a state");
    c_resume: cover property (resume_req
        && next_power_state == stop_reaction_pkg::NEXT_QS_ACT);
    c_refused: cover property (obj_err);
    c_immediate: cover property (stop_action == stop_reaction_pkg::ACT_IMMEDIATE);
endmodule : drive_stop_reaction_select_asserts
bind drive_stop_reaction_select drive_stop_reaction_select_asserts #(
    .DATA_W(DATA_W)
) u_chk (
    .clk(clk), .rst(rst), .clk_en(clk_en), .obj_wr(obj_wr), .obj_rd(obj_rd),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
    .obj_ack(obj_ack), .obj_err(obj_err), .control_word(control_word),
    .resume_req(resume_req), .brake_done(brake_done),
    .stop_action(stop_action), .next_power_state(next_power_state),
    .drive_energized(drive_energized), .halt_active(halt_active)
);
`default_nettype wire

// ==== verification/fieldbus_master_model.sv ====
// Purpose: Fieldbus master issuing option accesses and commands
// Assumes: One access at a time, answer one cycle after the take
// Notes:   Write data is inverted after release, never left stale
`timescale 1ns/1ns
`default_nettype none
module fieldbus_master_model (
    input  wire logic        clk,
    input  wire logic [15:0] obj_rdata,
    input  wire logic        obj_ack,
    input  wire logic        obj_err,
    output var  logic        obj_wr,
    output var  logic        obj_rd,
    output var  logic [15:0] obj_index,
    output var  logic [15:0] obj_wdata,
    output var  logic [15:0] control_word,
    output var  logic        resume_req
);
    initial
    begin
        obj_wr = 1'b0;
        obj_rd = 1'b0;
        obj_index = 16'h0000;
        obj_wdata = 16'h0000;
        control_word = 16'h0000;
        resume_req = 1'b0;
    end
    // Reserved codes are only sent when a scenario asks for them
    task automatic acc(input logic w, input logic [15:0] i, d,
                       output logic [15:0] q, output logic a, e);
        @(posedge clk);
        obj_wr <= w;
        obj_rd <= !w;
        obj_index <= i;
        obj_wdata <= d;
        @(posedge clk);
        obj_wr <= 1'b0;
        obj_rd <= 1'b0;
        obj_wdata <= ~d;
        #1;
        q = obj_rdata;
        a = obj_ack;
        e = obj_err;
    endtask : acc
    task automatic set_halt(input logic v);
        control_word[8] <= v;
    endtask : set_halt
    task automatic set_resume(input logic v);
        resume_req <= v;
    endtask : set_resume
endmodule : fieldbus_master_model
`default_nettype wire

// ==== verification/tb_drive_stop_reaction_select.sv ====
// Purpose: Self-checking bench for the stop reaction selector
// Assumes: clk_en high but for one freeze check; idle selector
// Notes:   Shutdown/disable coast next state is not fixed, so it goes unchecked
`timescale 1ns/1ns
`default_nettype none
module tb_drive_stop_reaction_select;
    localparam stop_reaction_pkg::action_t IMM = stop_reaction_pkg::ACT_IMMEDIATE;
    localparam stop_reaction_pkg::action_t SLOW = stop_reaction_pkg::ACT_SLOW_RAMP;
    localparam stop_reaction_pkg::action_t QSR = stop_reaction_pkg::ACT_QS_RAMP;
    localparam stop_reaction_pkg::action_t COAST = stop_reaction_pkg::ACT_COAST;
    localparam stop_reaction_pkg::follow_t SOD = stop_reaction_pkg::NEXT_SOD;
    localparam stop_reaction_pkg::follow_t QSA = stop_reaction_pkg::NEXT_QS_ACT;
    localparam stop_reaction_pkg::follow_t ANY = stop_reaction_pkg::NEXT_HOLD;
    logic clk = 1'b0, rst = 1'b1, brake_done = 1'b0, clk_en = 1'b1;
    logic [4:0] req = 5'h00;
    logic obj_wr, obj_rd, resume_req, ak, er;
    logic [15:0] obj_index, obj_wdata, obj_rdata, control_word, q;
    logic obj_ack, obj_err, drive_energized, halt_active;
    stop_reaction_pkg::action_t stop_action;
    stop_reaction_pkg::follow_t next_power_state;
    int miscompares = 0, n_compared = 0;
    always #5 clk = ~clk;
    drive_stop_reaction_select uut (
        .clk(clk), .rst(rst), .clk_en(clk_en),
        .obj_wr(obj_wr), .obj_rd(obj_rd),
        .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .control_word(control_word),
        .quick_stop_req(req[0]), .shutdown_req(req[1]), .disable_req(req[2]),
        .fault_req(req[4]), .resume_req(resume_req), .brake_done(brake_done),
        .stop_action(stop_action), .next_power_state(next_power_state),
        .drive_energized(drive_energized), .halt_active(halt_active));
    fieldbus_master_model m (
        .clk(clk), .obj_rdata(obj_rdata), .obj_ack(obj_ack), .obj_err(obj_err),
        .obj_wr(obj_wr), .obj_rd(obj_rd), .obj_index(obj_index),
        .obj_wdata(obj_wdata), .control_word(control_word),
        .resume_req(resume_req));
    task automatic results;
        if (miscompares == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    task automatic chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // Event k: 0 quick stop, 1 shutdown, 2 disable, 3 halt, 4 fault
    task automatic ev(input int k, input logic [15:0] c,
                      input stop_reaction_pkg::action_t a,
                      input stop_reaction_pkg::follow_t f);
        m.acc(1'b1, 16'h605a + 16'(k), c, q, ak, er);
        chk("write ack", 16'h0001, 16'(ak));
        @(posedge clk);
        if (k == 3) m.set_halt(1'b1); else req[k] <= 1'b1;
        @(posedge clk);
        if (k == 3) m.set_halt(1'b0); else req[k] <= 1'b0;
        #1 chk("stop_action", 16'(a), 16'(stop_action));
        if (k == 3) chk("halt_active", 16'h0001, 16'(halt_active));
        // Ramps wait for the brake report, so stall it one cycle
        if (a == SLOW || a == QSR)
        begin
            @(posedge clk);
            brake_done <= 1'b1;
            @(posedge clk);
            brake_done <= 1'b0;
        end
        else @(posedge clk);
        #1 if (f != ANY) chk("next state", 16'(f), 16'(next_power_state));
        if (a == COAST) chk("coasting", 16'h0000, 16'(drive_energized));
        if (f == QSA)
        begin
            chk("energized", 16'h0001, 16'(drive_energized));
            @(posedge clk);
            m.set_resume(1'b1);
            @(posedge clk);
            m.set_resume(1'b0);
            #1 chk("resume state", 16'(stop_reaction_pkg::NEXT_OP_EN),
                   16'(next_power_state));
        end
    endtask : ev
    initial
    begin
        logic [15:0] rv [5];
        rv = '{stop_reaction_pkg::RST_QUICK_STOP, stop_reaction_pkg::RST_SHUTDOWN,
               stop_reaction_pkg::RST_DISABLE, stop_reaction_pkg::RST_HALT,
               stop_reaction_pkg::RST_FAULT};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            m.acc(1'b0, 16'h605a + 16'(k), 16'h0000, q, ak, er);
            chk("reset value", rv[k], q);
        end
        // A write while frozen must neither land nor be answered
        @(posedge clk);
        clk_en <= 1'b0;
        m.acc(1'b1, 16'h605e, 16'h0001, q, ak, er);
        chk("frozen ack", 16'h0000, 16'(ak));
        @(posedge clk);
        clk_en <= 1'b1;
        m.acc(1'b0, 16'h605e, 16'h0000, q, ak, er);
        chk("frozen write", stop_reaction_pkg::RST_FAULT, q);
        m.acc(1'b1, 16'h605f, 16'h0002, q, ak, er);
        chk("unmapped err", 16'h0002, 16'({er, ak}));
        m.acc(1'b0, 16'h6059, 16'h0000, q, ak, er);
        chk("unmapped rdata", 16'h0000, q);
        m.acc(1'b1, 16'h605d, 16'h0002, q, ak, er);
        m.acc(1'b0, 16'h605d, 16'h0000, q, ak, er);
        chk("readback", 16'h0002, q);
        ev(0, 16'h0000, IMM, SOD);
        ev(0, 16'h0001, SLOW, SOD);
        ev(0, 16'h0002, QSR, SOD);
        ev(0, 16'h0005, SLOW, QSA);
        ev(0, 16'h0006, QSR, QSA);
        ev(1, 16'h0000, COAST, ANY);
        ev(1, 16'h0001, SLOW, SOD);
        ev(2, 16'h0000, COAST, ANY);
        ev(2, 16'h0001, SLOW, SOD);
        ev(3, 16'h0001, SLOW, QSA);
        ev(3, 16'h0002, QSR, QSA);
        ev(4, 16'h0000, COAST, SOD);
        ev(4, 16'h0001, SLOW, SOD);
        ev(4, 16'h0002, QSR, SOD);
        ev(1, 16'h0002, COAST, ANY);
        ev(2, 16'h0002, COAST, ANY);
        ev(0, 16'hffff, IMM, SOD);
        results();
    end
    initial
    begin
        repeat (2000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule : tb_drive_stop_reaction_select
`default_nettype wire
